// >>> bench/urwk_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host port model: line conditions seen by the transceiver.
// ----------------------------------------------------------------
module urwk_host_model (
    // Clock, reset and bench commands.
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       traffic,
    input  wire logic       reset_cmd,
    input  wire logic [7:0] answer_lag,
    input  wire logic       k_drive_ff,
    // Line conditions.
    output logic            bus_idle_pin,
    output logic            bus_resume_pin,
    output logic            bus_reset_pin
);
    logic       k_prev_ff;                                    // Drive level one cycle back.
    logic [7:0] lag_ff;                                       // Cycles before the host answers.
    logic [3:0] rs_ff;                                        // Resume cycles left.
    wire logic [7:0] nxt_lag = (k_prev_ff && !k_drive_ff) ? answer_lag + 8'h01 : lag_ff - 8'(lag_ff != 8'h00);
    wire logic [3:0] nxt_rs  = (lag_ff == 8'h01) ? 4'hf : rs_ff - 4'(rs_ff != 4'h0);
    // A finished K is answered by resume, promptly or late as the bench asks.
    always_ff @(posedge clock) begin
        k_prev_ff <= !srst && k_drive_ff;
        lag_ff    <= srst ? 8'h00 : nxt_lag;
        rs_ff     <= srst ? 4'h0 : nxt_rs;
    end
    assign bus_resume_pin = rs_ff != 4'h0;
    assign bus_reset_pin  = reset_cmd;
    // Any driven state, the device's own K included, ends the idle line.
    assign bus_idle_pin   = !(traffic || reset_cmd || bus_resume_pin || k_drive_ff);
endmodule : urwk_host_model

// >>> bench/urwk_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the remote wakeup block.
// ----------------------------------------------------------------
module urwk_props #(
    parameter int SUSPEND_CYC = 32'h0000_001e,
    parameter int WAKE_CYC    = 32'h0000_0032,
    parameter int DRIVE_CYC   = 32'h0000_0014
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Line and software inputs.
    input wire logic bus_idle_pin,
    input wire logic bus_resume_pin,
    input wire logic bus_reset_pin,
    input wire logic osc_running_pin,
    input wire logic wakeup_req_write,
    // Outputs under watch.
    input wire logic wakeup_request_ff,
    input wire logic suspend_status_ff,
    input wire logic suspended_ff,
    input wire logic k_drive_ff
);
    int      idle_run_ff;                                     // Idle line samples in a row.
    int      drv_run_ff;                                      // K drive cycles in a row.
    // Nets need a four-state type, so the next counts are plain 32-bit vectors.
    wire logic [31:0] nxt_idle_run = bus_idle_pin ? idle_run_ff + 1 : 0;
    wire logic [31:0] nxt_drv_run  = k_drive_ff ? drv_run_ff + 1 : 0;
    // Runs restart on reset, so a stale count cannot satisfy a check.
    always_ff @(posedge clock) begin
        idle_run_ff <= srst ? 0 : nxt_idle_run;
        drv_run_ff  <= srst ? 0 : nxt_drv_run;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Oscillator held stopped; host leaving suspend while the device is quiet.
    sequence s_osc_off; !osc_running_pin [*5]; endsequence
    sequence s_release; ((bus_resume_pin || bus_reset_pin) && !k_drive_ff) [*5]; endsequence
    property p_k_in_susp; k_drive_ff |-> suspended_ff; endproperty
    a_k_in_susp: assert property (p_k_in_susp) else $error("K drive while awake");
    property p_awake_wr; wakeup_req_write && !suspended_ff && !wakeup_request_ff |=> !wakeup_request_ff; endproperty
    a_awake_wr: assert property (p_awake_wr) else $error("request kept while awake");
    property p_early; $rose(k_drive_ff) |-> idle_run_ff >= WAKE_CYC; endproperty
    a_early: assert property (p_early) else $error("K drive before idle threshold");
    property p_susp; $rose(suspended_ff) |-> idle_run_ff >= SUSPEND_CYC; endproperty
    a_susp: assert property (p_susp) else $error("suspend before idle threshold");
    property p_drive_len; $fell(k_drive_ff) |-> drv_run_ff == DRIVE_CYC; endproperty
    a_drive_len: assert property (p_drive_len) else $error("K drive length wrong");
    property p_osc; s_osc_off |-> !$rose(k_drive_ff); endproperty
    a_osc: assert property (p_osc) else $error("K drive with oscillator stopped");
    property p_clear; $fell(suspended_ff) && !$past(wakeup_req_write) |-> !wakeup_request_ff; endproperty
    a_clear: assert property (p_clear) else $error("request kept after release");
    property p_release; s_release |-> ##[0:2] (!suspended_ff && !suspend_status_ff); endproperty
    a_release: assert property (p_release) else $error("suspend kept after resume");
endmodule : urwk_props

bind urwk_remote_wakeup urwk_props #(.SUSPEND_CYC(SUSPEND_CYC), .WAKE_CYC(WAKE_CYC), .DRIVE_CYC(DRIVE_CYC))
    urwk_props_i (.clock, .srst, .bus_idle_pin, .bus_resume_pin, .bus_reset_pin, .osc_running_pin,
    .wakeup_req_write, .wakeup_request_ff, .suspend_status_ff, .suspended_ff, .k_drive_ff);

// >>> bench/usb_remote_wakeup_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the remote wakeup block.
// ----------------------------------------------------------------
module usb_remote_wakeup_bench;
    localparam int SUS = 32'h0000_001e;                       // Short suspend threshold.
    localparam int WAK = 32'h0000_0032;                       // Short wakeup idle threshold.
    logic        clock, srst, osc_running_pin, wakeup_req_write, suspend_int_enable, traffic, reset_cmd;
    logic        bus_idle_pin, bus_resume_pin, bus_reset_pin, k_drive_ff, k_oe_n_ff;
    logic        wakeup_request_ff, suspend_status_ff, suspended_ff, intr_n_ff;
    logic [7:0]  answer_lag;
    logic [31:0] rng;
    int          n_fail, checked, cyc, t, m_idle;
    urwk_remote_wakeup #(.SUSPEND_CYC(18'h0_001e), .WAKE_CYC(18'h0_0032), .DRIVE_CYC(18'h0_0014))
        urwk_remote_wakeup_i (.clock, .srst, .bus_idle_pin, .bus_resume_pin, .bus_reset_pin,
        .osc_running_pin, .wakeup_req_write, .suspend_int_enable, .wakeup_request_ff,
        .suspend_status_ff, .suspended_ff, .intr_n_ff, .k_drive_ff, .k_oe_n_ff);
    urwk_host_model urwk_host_model_i (.clock, .srst, .traffic, .reset_cmd, .answer_lag, .k_drive_ff,
        .bus_idle_pin, .bus_resume_pin, .bus_reset_pin);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Reference idle run and the cycle ceiling that cuts a hang short.
    always @(posedge clock) begin
        m_idle <= bus_idle_pin ? m_idle + 1 : 0;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : cmp_bit
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    task automatic pulse_write();
        wakeup_req_write = 1'b1;
        tick(1);
        wakeup_req_write = 1'b0;
    endtask : pulse_write
    // Bounded wait for the K drive to start, or for the device to wake.
    task automatic wait_for(input bit drive);
        t = 0;
        while ((drive ? k_drive_ff !== 1'b1 : suspended_ff !== 1'b0) && t < 200) begin
            tick(1);
            t++;
        end
    endtask : wait_for
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    initial begin
        {srst, osc_running_pin, suspend_int_enable, traffic} = 4'hf;
        {wakeup_req_write, reset_cmd, answer_lag} = 10'h000;
        rng = 32'h0000_d2cb;
        tick(5);
        srst = 1'b0;
        tick(2);
        cmp_bit(intr_n_ff, 1'b1, "interrupt after reset");
        pulse_write();
        tick(3);
        cmp_bit(wakeup_request_ff | k_drive_ff, 1'b0, "request while awake");
        // One busy cycle restarts the idle count; then a bus reset ends suspend.
        traffic = 1'b0;
        tick(20);
        traffic = 1'b1;
        tick(1);
        traffic = 1'b0;
        tick(SUS - 15);
        cmp_bit(suspended_ff, 1'b0, "idle restart");
        tick(SUS);
        cmp_bit(intr_n_ff, 1'b0, "suspend interrupt");
        reset_cmd = 1'b1;
        tick(6);
        cmp_bit(suspended_ff | !intr_n_ff, 1'b0, "bus reset release");
        reset_cmd = 1'b0;
        // Random early and late requests, interrupt enable and host answer lag.
        for (int i = 0; i < 6; i++) begin
            rng = xs(rng);
            suspend_int_enable = rng[0];
            answer_lag = {3'b000, rng[12:8]};
            traffic = 1'b0;
            tick(SUS + 8);
            cmp_bit(suspend_status_ff & suspended_ff, rng[0], "suspend status");
            if (rng[1]) tick(WAK - SUS);
            pulse_write();
            cmp_bit(k_drive_ff, rng[1], "drive at once");
            wait_for(1'b1);
            cmp_bit(rng[1] ? t == 0 : m_idle >= WAK && m_idle <= WAK + 6, 1'b1, "drive start");
            cmp_bit(wakeup_request_ff & !k_oe_n_ff, 1'b1, "drive enable");
            wait_for(1'b0);
            cmp_bit(wakeup_request_ff | !intr_n_ff, 1'b0, "request cleared");
            // The host's resume outlasts the release by about twelve cycles; stay busy past it
            // so that the next idle run starts at a known cycle and suspend is due in time.
            traffic = 1'b1;
            tick(16);
        end
        // A stopped oscillator holds the request pending until it runs again.
        osc_running_pin = 1'b0;
        traffic = 1'b0;
        tick(WAK + 10);
        pulse_write();
        tick(40);
        cmp_bit(wakeup_request_ff & !k_drive_ff, 1'b1, "oscillator stopped");
        osc_running_pin = 1'b1;
        wait_for(1'b1);
        cmp_bit(t <= 5, 1'b1, "oscillator restarted");
        wait_for(1'b0);
        cmp_bit(wakeup_request_ff, 1'b0, "request cleared");
        give_verdict();
    end
endmodule : usb_remote_wakeup_bench

// >>> rtl/urwk_idle_timer.sv
`timescale 1ns/1ps

`include "urwk_map.svh"

// Counts how long the bus has stayed idle and flags the two thresholds.
module urwk_idle_timer #(
    parameter logic [`URWK_CNT_W-1:0] SUSPEND_CYC = `URWK_CNT_W'(`URWK_SUSPEND_CYC),
    parameter logic [`URWK_CNT_W-1:0] WAKE_CYC    = `URWK_CNT_W'(`URWK_WAKE_IDLE_CYC)
) (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic srst,
    // Synchronised idle level of the bus.
    input  wire logic bus_idle,
    // Threshold flags.
    output logic      idle_suspend_ff,
    output logic      idle_wake_ff
);

    // ------------------------------------------------------------------------
    // Idle counter
    // ------------------------------------------------------------------------

    logic [`URWK_CNT_W-1:0] count_ff;      // Cycles of unbroken idle.
    logic [`URWK_CNT_W-1:0] nxt_count;     // Next count value.
    wire                    at_limit;      // Counter has reached the longer threshold.

    // Saturate at the wake threshold so the counter never wraps during a long suspend.
    assign at_limit  = (count_ff >= WAKE_CYC);
    assign nxt_count = !bus_idle ? '0 : (at_limit ? count_ff : count_ff + 1'b1);

    // Any activity restarts the count; the flags compare against both thresholds.
    always_ff @(posedge clock) begin
        if (srst) begin
            count_ff        <= '0;
            idle_suspend_ff <= 1'b0;
            idle_wake_ff    <= 1'b0;
        end else begin
            count_ff        <= nxt_count;
            idle_suspend_ff <= (nxt_count >= SUSPEND_CYC);
            idle_wake_ff    <= (nxt_count >= WAKE_CYC);
        end
    end

endmodule : urwk_idle_timer

// >>> rtl/urwk_map.svh
`ifndef URWK_MAP_SVH
`define URWK_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing constants
// ----------------------------------------------------------------------------

// System clock rate in kHz (20 MHz, 50 ns period).
`define URWK_CLK_KHZ        20000
// Bus idle time after which the device suspends, in microseconds.
`define URWK_SUSPEND_US     3000
// Bus idle time that must pass before remote wakeup may start, in microseconds.
`define URWK_WAKE_IDLE_US   5000
// Length of the remote wakeup K drive, in microseconds.
`define URWK_DRIVE_US       10000
// Least times round up to whole cycles.
`define URWK_SUSPEND_CYC    ((`URWK_SUSPEND_US * `URWK_CLK_KHZ + 999) / 1000)
`define URWK_WAKE_IDLE_CYC  ((`URWK_WAKE_IDLE_US * `URWK_CLK_KHZ + 999) / 1000)
`define URWK_DRIVE_CYC      ((`URWK_DRIVE_US * `URWK_CLK_KHZ + 999) / 1000)
// Width of every cycle counter; holds the longest count above.
`define URWK_CNT_W          18

// ----------------------------------------------------------------------------
// Register field positions
// ----------------------------------------------------------------------------

// Wakeup request bit within the device state register.
`define URWK_DEVSTATE_WAKEUP_BIT  4
// Suspend bit within the interrupt status register.
`define URWK_INTERRUPT_STATUS_REGISTER_SUSPEND_BIT  6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------

`define URWK_WAKEUP_RST   1'b0
`define URWK_SUSPIRQ_RST  1'b0

`endif

// >>> rtl/urwk_pkg.sv
// ----------------------------------------------------------------------------
// Types shared by the remote wakeup block
// ----------------------------------------------------------------------------

package urwk_pkg;

    // Link power states; Gray coded along awake, suspend, drive, wait for resume.
    typedef enum logic [1:0] {
        URWK_AWAKE   = 2'b00,
        URWK_SUSPEND = 2'b01,
        URWK_DRIVE_K = 2'b11,
        URWK_WAIT_RS = 2'b10
    } urwk_state_t;

endpackage : urwk_pkg

// >>> rtl/urwk_remote_wakeup.sv
`timescale 1ns/1ps

`include "urwk_map.svh"

// Overview of operation
// - Wakeup signalling only while suspended.
// - Early request waits for five ms idle.
// - Request after five ms idle drives immediately.
// - Resume releasing suspend clears D4 automatically.
// - No wakeup while the oscillator is stopped.
// - Suspend after three ms of idle bus.
// - Resume or reset clears suspend interrupt D6.
module urwk_remote_wakeup #(
    parameter logic [`URWK_CNT_W-1:0] SUSPEND_CYC = `URWK_CNT_W'(`URWK_SUSPEND_CYC),
    parameter logic [`URWK_CNT_W-1:0] WAKE_CYC    = `URWK_CNT_W'(`URWK_WAKE_IDLE_CYC),
    parameter logic [`URWK_CNT_W-1:0] DRIVE_CYC   = `URWK_CNT_W'(`URWK_DRIVE_CYC)
) (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic srst,
    // Line conditions from the transceiver, asynchronous to the clock.
    input  wire logic bus_idle_pin,
    input  wire logic bus_resume_pin,
    input  wire logic bus_reset_pin,
    // Oscillator status, asynchronous to the clock.
    input  wire logic osc_running_pin,
    // Software write of one to the wakeup request bit, one clock pulse.
    input  wire logic wakeup_req_write,
    // Suspend interrupt enable bit from the enable register.
    input  wire logic suspend_int_enable,
    // Register state seen by software.
    output logic      wakeup_request_ff,
    output logic      suspend_status_ff,
    output logic      suspended_ff,
    // Interrupt output, active low.
    output logic      intr_n_ff,
    // Remote wakeup drive of the K state and its output enable, active low.
    output logic      k_drive_ff,
    output logic      k_oe_n_ff
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------

    localparam int NSYNC = 4;

    wire  [NSYNC-1:0] raw_in;       // Pins gathered for synchronisation.
    logic             meta_ff [NSYNC]; // First stage; read only by the second.
    logic             sync_ff [NSYNC]; // Second stage; one element per process, so no shared driver.

    assign raw_in = {osc_running_pin, bus_reset_pin, bus_resume_pin, bus_idle_pin};

    // Two flops per pin so that no decode sees a metastable level.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (srst) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= raw_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    wire bus_idle    = sync_ff[0];   // Bus undriven.
    wire bus_resume  = sync_ff[1];   // Host resume seen.
    wire bus_reset   = sync_ff[2];   // Bus reset seen.
    wire osc_running = sync_ff[3];   // Oscillator running.

    // ------------------------------------------------------------------------
    // Idle time measurement
    // ------------------------------------------------------------------------

    wire idle_suspend;   // Idle for the suspend threshold.
    wire idle_wake;      // Idle for the wakeup threshold.

    // While we drive K ourselves the line is not idle; the counter sees that as activity.
    urwk_idle_timer #(
        .SUSPEND_CYC     (SUSPEND_CYC),
        .WAKE_CYC        (WAKE_CYC)
    ) u_idle (
        .clock           (clock),
        .srst            (srst),
        .bus_idle        (bus_idle),
        .idle_suspend_ff (idle_suspend),
        .idle_wake_ff    (idle_wake)
    );

    // ------------------------------------------------------------------------
    // Decode of state transitions
    // ------------------------------------------------------------------------

    urwk_pkg::urwk_state_t   state_ff;    // Link power state.
    urwk_pkg::urwk_state_t   nxt_state;   // Next link power state.
    logic [`URWK_CNT_W-1:0]  drive_ff;    // Cycles of K drive so far.

    wire in_suspend  = (state_ff == urwk_pkg::URWK_SUSPEND);
    wire in_drive    = (state_ff == urwk_pkg::URWK_DRIVE_K);
    wire is_awake    = (state_ff == urwk_pkg::URWK_AWAKE);
    wire wake_exit   = bus_resume || bus_reset;
    // The stored request counts, and so does a write in this very cycle.
    wire req_live    = wakeup_request_ff || wakeup_req_write;
    // Start needs suspend, the idle time, a request and a running oscillator.
    wire start_drive = in_suspend && !wake_exit && req_live && idle_wake && osc_running;
    wire enter_susp  = is_awake && idle_suspend && !bus_reset;
    wire drive_done  = in_drive && (drive_ff >= DRIVE_CYC - 1'b1);
    wire release_sus = !is_awake && wake_exit && !in_drive;

    // Next state selection.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            urwk_pkg::URWK_AWAKE: begin
                // Enough idle moves the device into suspend.
                if (enter_susp) begin
                    nxt_state = urwk_pkg::URWK_SUSPEND;
                end
            end
            urwk_pkg::URWK_SUSPEND: begin
                // Host activity wins over a pending wakeup.
                if (wake_exit) begin
                    nxt_state = urwk_pkg::URWK_AWAKE;
                end else if (start_drive) begin
                    nxt_state = urwk_pkg::URWK_DRIVE_K;
                end
            end
            urwk_pkg::URWK_DRIVE_K: begin
                // Our own K shows as resume, so only the timer ends the drive.
                if (drive_done) begin
                    nxt_state = urwk_pkg::URWK_WAIT_RS;
                end
            end
            urwk_pkg::URWK_WAIT_RS: begin
                // The host answers with resume, which releases suspend.
                if (wake_exit) begin
                    nxt_state = urwk_pkg::URWK_AWAKE;
                end
            end
            default: begin
                nxt_state = urwk_pkg::URWK_AWAKE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------------

    // A write outside suspend is dropped so it can never cause signalling later.
    // A write arriving in the releasing cycle wins over the automatic clear.
    wire req_set   = wakeup_req_write && !is_awake;
    wire nxt_req   = req_set ? 1'b1 : (release_sus ? 1'b0 : wakeup_request_ff);
    // Suspend status is raised only when enabled, as a disabled cause reads zero.
    wire set_stat  = enter_susp && suspend_int_enable;
    wire clr_stat  = wake_exit || !suspend_int_enable;
    wire nxt_stat  = set_stat ? 1'b1 : (clr_stat ? 1'b0 : suspend_status_ff);
    wire nxt_susp  = (nxt_state != urwk_pkg::URWK_AWAKE);
    wire nxt_drive = (nxt_state == urwk_pkg::URWK_DRIVE_K);
    wire [`URWK_CNT_W-1:0] nxt_dcnt = in_drive ? drive_ff + 1'b1 : '0;

    // ------------------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------------------

    // State machine and drive timer.
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= urwk_pkg::URWK_AWAKE;
            drive_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            drive_ff <= nxt_dcnt;
        end
    end

    // Software visible bits and the interrupt pin.
    always_ff @(posedge clock) begin
        if (srst) begin
            wakeup_request_ff <= `URWK_WAKEUP_RST;
            suspend_status_ff <= `URWK_SUSPIRQ_RST;
            suspended_ff      <= 1'b0;
            intr_n_ff         <= 1'b1;
        end else begin
            wakeup_request_ff <= nxt_req;
            suspend_status_ff <= nxt_stat;
            suspended_ff      <= nxt_susp;
            intr_n_ff         <= !nxt_stat;
        end
    end

    // Line drive; enable low only while the K state is driven.
    always_ff @(posedge clock) begin
        if (srst) begin
            k_drive_ff <= 1'b0;
            k_oe_n_ff  <= 1'b1;
        end else begin
            k_drive_ff <= nxt_drive;
            k_oe_n_ff  <= !nxt_drive;
        end
    end

endmodule : urwk_remote_wakeup
